// ==== src/pmrs_pkg.sv ====
package pmrs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  typedef logic [DATA_W-1:0] pmrs_word_t;
  typedef logic [ADDR_W-1:0] pmrs_addr_t;

  // register offsets
  localparam pmrs_addr_t OFF_CTRL  = 5'h00;
  localparam pmrs_addr_t OFF_STAT  = 5'h01;
  localparam pmrs_addr_t OFF_ID_UP = 5'h02;
  localparam pmrs_addr_t OFF_ID_LO = 5'h03;
  localparam pmrs_addr_t OFF_ADV   = 5'h04;
  localparam pmrs_addr_t OFF_LP    = 5'h05;

  // basic control fields
  localparam int CTL_SOFT_RESET     = 15;
  localparam int CTL_LOOPBACK       = 14;
  localparam int CTL_FORCE_100      = 13;
  localparam int CTL_NEG_ON         = 12;
  localparam int CTL_POWER_DOWN     = 11;
  localparam int CTL_ISOLATE        = 10;
  localparam int CTL_NEG_RESTART    = 9;
  localparam int CTL_FULL_DUPLEX    = 8;
  localparam int CTL_XOVER_FLAVOR   = 5;
  localparam int CTL_FIXED_STRAIGHT = 4;
  localparam int CTL_AUTO_XOVER_OFF = 3;
  localparam int CTL_FAR_FAULT_OFF  = 2;
  localparam int CTL_TX_OFF         = 1;
  localparam int CTL_INDICATOR_OFF  = 0;

  localparam pmrs_word_t CTL_RESET      = 16'h3120;
  localparam pmrs_word_t CTL_STORE_MASK = 16'h7d3f;
  localparam pmrs_word_t CTL_RSVD_MASK  = 16'h00c0;

  // basic status fields
  localparam pmrs_word_t STAT_FIXED    = 16'h7808;
  localparam int         STAT_NEG_DONE = 5;
  localparam int         STAT_FAULT    = 4;
  localparam int         STAT_LINK     = 2;
  localparam logic [4:0] STAT_ABIL_TOP = 5'h0f;
  localparam int         STAT_ABIL_NEG = 3;
  localparam int         STAT_EXT      = 0;
  localparam int         STAT_FOUR_PR  = 15;

  // advertisement and partner ability
  localparam pmrs_word_t ADV_RESET     = 16'h0de1;
  localparam pmrs_word_t ADV_WR_MASK   = 16'h07e0;
  localparam logic [4:0] ADV_SELECTOR  = 5'h01;
  localparam pmrs_word_t LP_CAPT_MASK  = 16'h05e0;
  localparam pmrs_word_t LP_FIXED      = 16'h0001;
  localparam pmrs_word_t WORD_ZERO     = 16'h0000;

  // pins crossing into the core clock
  localparam int PIN_W = DATA_W + 4;

endpackage : pmrs_pkg

// ==== src/pmrs_pin_sync.sv ====
`timescale 1ns/1ps
module pmrs_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      // a change counts once the second and third stages agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_reg  <= 1'b0;
        end else begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q[i] = q_reg;
    end
  endgenerate

endmodule : pmrs_pin_sync

// ==== src/pmrs_register_set.sv ====
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - bit 4 fixes crossover: straight or crossed
// - bit 3 turns automatic crossover off
// - bit 2 suppresses far end fault detection
// - bit 1 stops the transmitter
// - bit 0 switches indicators off
// - status 14..11 read one, abilities
// - status 15 reads zero, no four-pair
// - status 0 reads zero, no extension
// - status 5 shows negotiation finished
// - status 4 shows remote fault
// - status 3 reads one, can negotiate
// - status 2 shows current link state
// - identifier split over offsets 2, 3
// - advertise bit 10 offers pause, resets one
// - advertise bits 8..5 offer speeds, reset one
// - advertise bits 4..0 fixed selector 00001
// - partner bit 10 shows partner pause
// - partner bits 8..5 show partner speeds
// - control bit 12 enables negotiation
module pmrs_register_set
  import pmrs_pkg::*;
#(
  parameter pmrs_word_t ID_UPPER = 16'h0a5a, // arbitrary value
  parameter pmrs_word_t ID_LOWER = 16'h5a0a  // arbitrary value
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  input  wire pmrs_addr_t ADDR,
  input  wire pmrs_word_t WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic       LINK_UP,
  input  wire logic       REMOTE_FAULT,
  input  wire logic       NEGOTIATION_DONE_IN,
  input  wire logic       AUTO_STRAIGHT,
  input  wire pmrs_word_t PARTNER_PAGE,
  output pmrs_word_t      RDATA,
  output logic            SOFT_RESET,
  output logic            LOOPBACK,
  output logic            FORCE_100,
  output logic            FULL_DUPLEX,
  output logic            POWER_DOWN,
  output logic            ISOLATE,
  output logic            NEGOTIATION_ON,
  output logic            NEGOTIATION_RESTART,
  output logic            XOVER_FLAVOR,
  output logic            MDI_STRAIGHT,
  output logic            FAR_FAULT_DETECT_OFF,
  output logic            TX_OFF,
  output logic            INDICATOR_OFF,
  output pmrs_word_t      ADV_PAGE
);

  logic             rst_meta_reg;
  logic             rst_n;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic             link_s;
  logic             fault_s;
  logic             done_s;
  logic             auto_s;
  pmrs_word_t       page_s;
  logic             done_d_reg;
  logic             done_rise;
  pmrs_word_t       ctrl_reg;
  pmrs_word_t       ctrl_next;
  pmrs_word_t       adv_reg;
  pmrs_word_t       adv_next;
  pmrs_word_t       lp_reg;
  pmrs_word_t       lp_next;
  pmrs_word_t       stat;
  pmrs_word_t       rdata_next;
  logic             wr_ctrl;
  logic             wr_adv;

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // pins from the line side
  assign pins_raw = {LINK_UP, REMOTE_FAULT, NEGOTIATION_DONE_IN,
                     AUTO_STRAIGHT, PARTNER_PAGE};

  pmrs_pin_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign link_s  = pins_s[PIN_W-1];
  assign fault_s = pins_s[PIN_W-2];
  assign done_s  = pins_s[PIN_W-3];
  assign auto_s  = pins_s[PIN_W-4];
  assign page_s  = pins_s[DATA_W-1:0];

  assign wr_ctrl = WR && (ADDR == OFF_CTRL);
  assign wr_adv  = WR && (ADDR == OFF_ADV);

  // control register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      if (WDATA[CTL_SOFT_RESET]) begin
        ctrl_next = CTL_RESET;
      end else begin
        ctrl_next = WDATA & CTL_STORE_MASK;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // advertisement register
  always_comb begin
    adv_next = adv_reg;
    if (wr_ctrl && WDATA[CTL_SOFT_RESET]) begin
      adv_next = ADV_RESET;
    end else if (wr_adv) begin
      adv_next = (WDATA & ADV_WR_MASK) |
                 (ADV_RESET & ~ADV_WR_MASK);
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      adv_reg <= ADV_RESET;
    end else begin
      adv_reg <= adv_next;
    end
  end

  // partner ability capture
  assign done_rise = done_s && !done_d_reg;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_d_reg <= 1'b0;
    end else begin
      done_d_reg <= done_s;
    end
  end

  always_comb begin
    lp_next = lp_reg;
    if (done_rise && ctrl_reg[CTL_NEG_ON]) begin
      lp_next = page_s & LP_CAPT_MASK;
    end else if (wr_ctrl && WDATA[CTL_SOFT_RESET]) begin
      lp_next = WORD_ZERO;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lp_reg <= WORD_ZERO;
    end else begin
      lp_reg <= lp_next;
    end
  end

  // status word
  always_comb begin
    stat = STAT_FIXED;
    stat[STAT_NEG_DONE] = done_s && ctrl_reg[CTL_NEG_ON];
    stat[STAT_FAULT] = fault_s &&
                       !ctrl_reg[CTL_FAR_FAULT_OFF];
    stat[STAT_LINK] = link_s;
  end

  // read decode
  always_comb begin
    rdata_next = WORD_ZERO;
    if (RD) begin
      if (ADDR == OFF_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (ADDR == OFF_STAT) begin
        rdata_next = stat;
      end else if (ADDR == OFF_ID_UP) begin
        rdata_next = ID_UPPER;
      end else if (ADDR == OFF_ID_LO) begin
        rdata_next = ID_LOWER;
      end else if (ADDR == OFF_ADV) begin
        rdata_next = adv_reg;
      end else if (ADDR == OFF_LP) begin
        rdata_next = lp_reg | LP_FIXED;
      end else begin
        rdata_next = WORD_ZERO;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= WORD_ZERO;
    end else begin
      RDATA <= rdata_next;
    end
  end

  // self-clearing command pulses
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SOFT_RESET          <= 1'b0;
      NEGOTIATION_RESTART <= 1'b0;
    end else begin
      SOFT_RESET          <= wr_ctrl && WDATA[CTL_SOFT_RESET];
      NEGOTIATION_RESTART <= wr_ctrl && WDATA[CTL_NEG_RESTART] &&
                             !WDATA[CTL_SOFT_RESET];
    end
  end

  // control levels to the line side
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      LOOPBACK             <= 1'b0;
      FORCE_100            <= 1'b0;
      FULL_DUPLEX          <= 1'b0;
      POWER_DOWN           <= 1'b0;
      ISOLATE              <= 1'b0;
      NEGOTIATION_ON       <= 1'b0;
      XOVER_FLAVOR         <= 1'b0;
      MDI_STRAIGHT         <= 1'b0;
      FAR_FAULT_DETECT_OFF <= 1'b0;
      TX_OFF               <= 1'b0;
      INDICATOR_OFF        <= 1'b0;
      ADV_PAGE             <= WORD_ZERO;
    end else begin
      LOOPBACK             <= ctrl_reg[CTL_LOOPBACK];
      FORCE_100            <= ctrl_reg[CTL_FORCE_100];
      FULL_DUPLEX          <= ctrl_reg[CTL_FULL_DUPLEX];
      POWER_DOWN           <= ctrl_reg[CTL_POWER_DOWN];
      ISOLATE              <= ctrl_reg[CTL_ISOLATE];
      NEGOTIATION_ON       <= ctrl_reg[CTL_NEG_ON];
      XOVER_FLAVOR         <= ctrl_reg[CTL_XOVER_FLAVOR];
      MDI_STRAIGHT         <= ctrl_reg[CTL_AUTO_XOVER_OFF] ?
                              ctrl_reg[CTL_FIXED_STRAIGHT] :
                              auto_s;
      FAR_FAULT_DETECT_OFF <= ctrl_reg[CTL_FAR_FAULT_OFF];
      TX_OFF               <= ctrl_reg[CTL_TX_OFF];
      INDICATOR_OFF        <= ctrl_reg[CTL_INDICATOR_OFF];
      ADV_PAGE             <= ctrl_reg[CTL_NEG_ON] ?
                              adv_reg : WORD_ZERO;
    end
  end

  // checks
  AST_XOVER_FIXED:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      ctrl_reg[CTL_AUTO_XOVER_OFF] |=>
        MDI_STRAIGHT == $past(ctrl_reg[CTL_FIXED_STRAIGHT]))
    else $error("fixed crossover not applied");

  AST_XOVER_AUTO:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      !ctrl_reg[CTL_AUTO_XOVER_OFF] |=> MDI_STRAIGHT == $past(auto_s))
    else $error("automatic crossover not followed");

  AST_FAULT_OFF:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      RD && ADDR == OFF_STAT && ctrl_reg[CTL_FAR_FAULT_OFF] |=>
        !RDATA[STAT_FAULT])
    else $error("fault shown while detection off");

  AST_TX_OFF:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      (wr_ctrl && !WDATA[CTL_SOFT_RESET]) ##1 !wr_ctrl |=>
        TX_OFF == $past(WDATA[CTL_TX_OFF], 2))
    else $error("transmit off does not follow write");

  AST_IND_OFF:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      (wr_ctrl && !WDATA[CTL_SOFT_RESET]) ##1 !wr_ctrl |=>
        INDICATOR_OFF == $past(WDATA[CTL_INDICATOR_OFF], 2))
    else $error("indicator off does not follow write");

  AST_STAT_FIXED:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      RD && ADDR == OFF_STAT |=>
        RDATA[STAT_FOUR_PR -: $bits(STAT_ABIL_TOP)] == STAT_ABIL_TOP &&
        RDATA[STAT_ABIL_NEG] && !RDATA[STAT_EXT])
    else $error("fixed status bits wrong");

  AST_STAT_LIVE:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      RD && ADDR == OFF_STAT |=>
        RDATA[STAT_LINK] == $past(link_s) &&
        RDATA[STAT_NEG_DONE] == $past(done_s && ctrl_reg[CTL_NEG_ON]))
    else $error("live status bits wrong");

  AST_ID_READ:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      RD && ADDR == OFF_ID_LO |=> RDATA == ID_LOWER)
    else $error("identifier read wrong");

  AST_ADV_RW:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      wr_adv ##1 (RD && ADDR == OFF_ADV && !WR) |=>
        (RDATA & ADV_WR_MASK) == ($past(WDATA, 2) & ADV_WR_MASK) &&
        RDATA[$bits(ADV_SELECTOR)-1:0] == ADV_SELECTOR)
    else $error("advertisement write not read back");

  AST_LP_CAPTURE:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      done_rise && ctrl_reg[CTL_NEG_ON] |=>
        lp_reg == ($past(page_s) & LP_CAPT_MASK))
    else $error("partner ability not captured");

  AST_ADV_GATE:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      !ctrl_reg[CTL_NEG_ON] |=> ADV_PAGE == WORD_ZERO)
    else $error("advertisement out while negotiation off");

  AST_RSVD_CTRL:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      wr_ctrl |=> (ctrl_reg & CTL_RSVD_MASK) == WORD_ZERO &&
        !ctrl_reg[CTL_SOFT_RESET] && !ctrl_reg[CTL_NEG_RESTART])
    else $error("reserved or self-clearing bit held");

  AST_SOFT_RESET:
    assert property (@(posedge CORE_CLK) disable iff (!rst_n)
      wr_ctrl && WDATA[CTL_SOFT_RESET] |=>
        ctrl_reg == CTL_RESET && adv_reg == ADV_RESET && SOFT_RESET)
    else $error("soft reset did not reload defaults");

endmodule : pmrs_register_set

// ==== verif/pmrs_far_end.sv ====
`timescale 1ns/1ps
module pmrs_far_end
  import pmrs_pkg::*;
(
  input  wire logic clk,
  output logic      link_up,
  output logic      remote_fault,
  output logic      neg_done,
  output logic      auto_straight,
  output pmrs_word_t page
);

  initial begin
    link_up       = 1'b0;
    remote_fault  = 1'b0;
    neg_done      = 1'b0;
    auto_straight = 1'b0;
    page          = 16'ha5a5;
  end

  // line levels of the far end, negotiation withdrawn
  task automatic set_pins(input logic l, input logic f, input logic x);
    @(posedge clk);
    link_up       <= l;
    remote_fault  <= f;
    auto_straight <= x;
    neg_done      <= 1'b0;
  endtask : set_pins

  // one negotiation; page moves again eight cycles after completion is flagged
  task automatic negotiate(input pmrs_word_t p);
    @(posedge clk);
    neg_done <= 1'b0;
    page     <= p;
    repeat (5) @(posedge clk);
    neg_done <= 1'b1;
    repeat (8) @(posedge clk);
    page <= ~p;
  endtask : negotiate

endmodule : pmrs_far_end

// ==== verif/pmrs_register_set_bench.sv ====
`timescale 1ns/1ps
module pmrs_register_set_bench;
  import pmrs_pkg::*;

  localparam pmrs_word_t ID_UP_EXP = 16'h1c3e; // arbitrary value
  localparam pmrs_word_t ID_LO_EXP = 16'h6b07; // arbitrary value

  logic       core_clk;
  logic       resetn;
  pmrs_addr_t addr;
  pmrs_word_t wdata;
  logic       wr;
  logic       rd;
  logic       link_up;
  logic       remote_fault;
  logic       neg_done;
  logic       auto_straight;
  pmrs_word_t page;
  pmrs_word_t rdata;
  pmrs_word_t adv_page;
  logic       neg_on;
  logic       mdi;
  logic       far;
  logic       tx;
  logic       ind;
  logic       soft_rst;
  logic       restart;
  logic       lpbk;
  logic       f100;
  logic       fdx;
  logic       pdn;
  logic       iso;
  logic       flavor;
  int         err_count;
  int         n_compared;

  pmrs_register_set #(
    .ID_UPPER (ID_UP_EXP),
    .ID_LOWER (ID_LO_EXP)
  ) pmrs_register_set_i (
    .CORE_CLK             (core_clk),
    .RESETN               (resetn),
    .ADDR                 (addr),
    .WDATA                (wdata),
    .WR                   (wr),
    .RD                   (rd),
    .LINK_UP              (link_up),
    .REMOTE_FAULT         (remote_fault),
    .NEGOTIATION_DONE_IN  (neg_done),
    .AUTO_STRAIGHT        (auto_straight),
    .PARTNER_PAGE         (page),
    .RDATA                (rdata),
    .SOFT_RESET           (soft_rst),
    .LOOPBACK             (lpbk),
    .FORCE_100            (f100),
    .FULL_DUPLEX          (fdx),
    .POWER_DOWN           (pdn),
    .ISOLATE              (iso),
    .NEGOTIATION_ON       (neg_on),
    .NEGOTIATION_RESTART  (restart),
    .XOVER_FLAVOR         (flavor),
    .MDI_STRAIGHT         (mdi),
    .FAR_FAULT_DETECT_OFF (far),
    .TX_OFF               (tx),
    .INDICATOR_OFF        (ind),
    .ADV_PAGE             (adv_page)
  );

  pmrs_far_end pmrs_far_end_i (
    .clk           (core_clk),
    .link_up       (link_up),
    .remote_fault  (remote_fault),
    .neg_done      (neg_done),
    .auto_straight (auto_straight),
    .page          (page)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input pmrs_word_t got, input pmrs_word_t exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input pmrs_addr_t a, input pmrs_word_t d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input pmrs_addr_t a, output pmrs_word_t d);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input pmrs_addr_t a, input pmrs_word_t exp);
    pmrs_word_t d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  // write, then read back in the very next cycle
  task automatic wr_rd_chk(input pmrs_addr_t a, input pmrs_word_t d,
                           input pmrs_word_t exp);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : wr_rd_chk

  // pin changes take a few cycles through the synchronisers
  task automatic poll(input pmrs_addr_t a, input pmrs_word_t exp);
    pmrs_word_t d;
    for (int i = 0; i < 20; i++) begin
      rd_reg(a, d);
      if (d === exp) break;
    end
    chk(d, exp);
    if (d !== exp) report_and_stop();
  endtask : poll

  task automatic t_defaults();
    rd_chk(OFF_CTRL, 16'h3120);
    rd_chk(OFF_STAT, 16'h7808);
    rd_chk(OFF_ID_UP, ID_UP_EXP);
    rd_chk(OFF_ID_LO, ID_LO_EXP);
    rd_chk(OFF_ADV, 16'h0de1);
    rd_chk(OFF_LP, 16'h0001);
    rd_chk(5'h1f, 16'h0000);
    chk({15'h0000, neg_on}, 16'h0001);
    chk(adv_page, 16'h0de1);
  endtask : t_defaults

  task automatic t_readonly();
    pmrs_addr_t ro [5] = '{OFF_STAT, OFF_ID_UP, OFF_ID_LO, OFF_LP, 5'h1f};
    foreach (ro[i]) wr_reg(ro[i], 16'hffff);
    t_defaults();
  endtask : t_readonly

  task automatic t_ctrl();
    pmrs_word_t tbl [6] = '{16'h3121, 16'h3122, 16'h3124,
                            16'h3128, 16'h3138, 16'h31d0};
    foreach (tbl[i]) begin
      wr_reg(OFF_CTRL, tbl[i]);
      rd_chk(OFF_CTRL, tbl[i] & 16'hff3f);
      chk({12'h000, mdi, far, tx, ind},
          {12'h000, tbl[i][3] & tbl[i][4], tbl[i][2:0]});
    end
    pmrs_far_end_i.set_pins(1'b0, 1'b0, 1'b1);
    wr_reg(OFF_CTRL, 16'h3120);
    for (int i = 0; i < 12 && mdi !== 1'b1; i++) @(posedge core_clk);
    chk({15'h0000, mdi}, 16'h0001);
    if (mdi !== 1'b1) report_and_stop();
    wr_reg(OFF_CTRL, 16'h3128);
    rd_chk(OFF_CTRL, 16'h3128);
    chk({15'h0000, mdi}, 16'h0000);
    wr_reg(OFF_CTRL, 16'h3120);
  endtask : t_ctrl

  task automatic t_adv();
    wr_rd_chk(OFF_ADV, 16'hffff, 16'h0fe1);
    chk(adv_page, 16'h0fe1);
    wr_rd_chk(OFF_ADV, 16'h0000, 16'h0801);
    chk(adv_page, 16'h0801);
    wr_reg(OFF_CTRL, 16'h2120);
    rd_chk(OFF_CTRL, 16'h2120);
    chk({adv_page[15:1], neg_on}, 16'h0000);
    wr_reg(OFF_CTRL, 16'h3120);
  endtask : t_adv

  task automatic t_pins();
    pmrs_far_end_i.set_pins(1'b1, 1'b1, 1'b0);
    poll(OFF_STAT, 16'h781c);
    wr_reg(OFF_CTRL, 16'h3124);
    poll(OFF_STAT, 16'h780c);
    wr_reg(OFF_CTRL, 16'h3120);
    pmrs_far_end_i.negotiate(16'hffff);
    poll(OFF_STAT, 16'h783c);
    rd_chk(OFF_LP, 16'h05e1);
    pmrs_far_end_i.set_pins(1'b0, 1'b0, 1'b0);
    poll(OFF_STAT, 16'h7808);
    rd_chk(OFF_LP, 16'h05e1);
    wr_reg(OFF_CTRL, 16'h2120);
    pmrs_far_end_i.negotiate(16'h0140);
    rd_chk(OFF_STAT, 16'h7808);
    rd_chk(OFF_LP, 16'h05e1);
  endtask : t_pins

  // command pulses, control levels and soft reset defaults
  task automatic t_cmds();
    wr_reg(OFF_ADV, 16'h0000);
    wr_reg(OFF_CTRL, 16'h4e00);
    #1;
    chk({14'h0000, restart, soft_rst}, 16'h0002);
    @(posedge core_clk);
    #1;
    chk({8'h00, restart, soft_rst, lpbk, f100, fdx, pdn, iso, flavor},
        16'h0026);
    rd_chk(OFF_CTRL, 16'h4c00);
    wr_reg(OFF_CTRL, 16'h8200);
    #1;
    chk({14'h0000, restart, soft_rst}, 16'h0001);
    @(posedge core_clk);
    #1;
    chk({8'h00, restart, soft_rst, lpbk, f100, fdx, pdn, iso, flavor},
        16'h0019);
    rd_chk(OFF_CTRL, 16'h3120);
    rd_chk(OFF_ADV, 16'h0de1);
    rd_chk(OFF_LP, 16'h0001);
  endtask : t_cmds

  // hardware reset in mid-run brings every default back
  task automatic t_reset();
    pmrs_far_end_i.set_pins(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(adv_page, 16'h0000);
    chk({15'h0000, neg_on}, 16'h0000);
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_defaults();
  endtask : t_reset

  initial begin
    err_count  = 0;
    n_compared = 0;
    resetn     = 1'b0;
    addr       = 5'h00;
    wdata      = 16'h0000;
    wr         = 1'b0;
    rd         = 1'b0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_defaults();
    t_readonly();
    t_ctrl();
    t_adv();
    t_pins();
    t_cmds();
    t_reset();
    report_and_stop();
  end

endmodule : pmrs_register_set_bench
